// [rtl/emi_off_chip_memory_port.sv]
// Off-chip memory port: APB registers, external move sequencer and port pin ownership.
// Summary of operation
// R1 - Address comes from data pointer, or page register high byte plus low byte.
// R2 - On-chip hits finish at once, ignoring the timing settings.
// R3 - Off-chip access length follows the timing register.
// R4 - Port pins are claimed only while an off-chip move runs.
// R5 - After an off-chip move all pins return to the port latches.
// R6 - Pins acting as inputs have their drivers off during the move.
// R7 - Output drive comes from software-set pin modes, never enabled by the port.
// R8 - Pins under latch control keep the mode given by the mode registers.
// R9 - Multiplexed: AD on port 4, high address on port 3, strobes on port 1.
// R10 - Non-multiplexed: data port 4, low address port 3, high address port 2.
// R11 - Multiplexed and plain layouts; four memory modes selectable.
// R12 - Latch strobe, setup, hold and strobe widths each configurable.
// R13 - Software sets pin modes, parks latches high, picks mode, then timing.
// R14 - Software keeps other signals off the port pins and skips the strobes.
// R15 - Latch strobe high while low address is on the shared lines.
// R16 - Off-chip access takes programmed timing plus four clocks.
// R17 - Split modes: below on-chip boundary goes on-chip, above goes off-chip.
// R18 - Access runs setup, latch strobe, read or write strobe, hold phases.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "emi_defines.svh"
module emi_off_chip_memory_port #(
	parameter logic [16:0] ONCHIP_SIZE = 17'h00800
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mov_req,
	input wire logic mov_write,
	input wire logic mov_wide,
	input wire logic [15:0] data_pointer,
	input wire logic [7:0] mov_lo,
	input wire logic [7:0] mov_wdata,
	output logic mov_done,
	output logic mov_onchip,
	output logic [7:0] mov_rdata,
	output logic [15:0] mov_addr,
	input wire logic [7:0] p1_in,
	output logic [7:0] p1_out,
	output logic [7:0] p1_oe,
	input wire logic [7:0] p2_in,
	output logic [7:0] p2_out,
	output logic [7:0] p2_oe,
	input wire logic [7:0] p3_in,
	output logic [7:0] p3_out,
	output logic [7:0] p3_oe,
	input wire logic [7:0] p4_in,
	output logic [7:0] p4_out,
	output logic [7:0] p4_oe
);
	logic [7:0] page_q;
	logic [7:0] tim_q;
	logic [7:0] mode_q;
	logic [7:0] latch_q [4];
	logic [7:0] pmode_q [4];
	logic [31:0] pin_s;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	emi_pkg::emi_state_t st_q;
	emi_pkg::emi_state_t st_d;
	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic wr_q;
	logic hi_q;
	logic mux_q;
	logic [15:0] addr_q;
	logic [7:0] wdata_q;
	logic [7:0] rdata_q;
	logic done_q;
	logic onchip_q;
	logic [2:0] cap_q;
	logic [7:0] out_d [4];
	logic [7:0] oe_d [4];
	logic [7:0] out_q [4];
	logic [7:0] oe_q [4];
	logic [15:0] ea;
	logic off;
	logic [15:0] eff;
	emi_pkg::emi_mode_t msel;
	logic apb_acc;
	logic bad_addr;
	logic [31:0] rd_word;
	logic [5:0] busy_cyc_q;
	logic [5:0] exp_q;

	emi_sync #(.W(32)) u_pin_sync (
		.clk(pclk),
		.rst_n(presetn),
		.din({p4_in, p3_in, p2_in, p1_in}),
		.dout(pin_s)
	);

	// Register writes happen on the second access cycle, the edge where pready is seen; read data is taken one edge earlier.
	assign apb_acc = psel & penable;
	assign bad_addr = (paddr[1:0] != 2'h0) || (paddr[7:6] != 2'h0);

	always_comb begin
		rd_word = 32'h0000_0000;
		case (paddr[5:4])
			`EMI_GRP_LATCH: rd_word = {24'h00_0000, latch_q[paddr[3:2]]};
			`EMI_GRP_PMODE: rd_word = {24'h00_0000, pmode_q[paddr[3:2]]};
			`EMI_GRP_PIN: rd_word = {24'h00_0000, pin_s[{paddr[3:2], 3'h0} +: 8]};
			default: begin
				case ({2'h0, paddr[5:0]})
					`EMI_OFS_PAGE: rd_word = {24'h00_0000, page_q};
					`EMI_OFS_TIM: rd_word = {24'h00_0000, tim_q};
					`EMI_OFS_MODE: rd_word = {24'h00_0000, mode_q};
					default: rd_word = {23'h00_0000, st_q != emi_pkg::EMI_IDLE, rdata_q};
				endcase
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= apb_acc & ~pready_q;
			pslverr_q <= apb_acc & ~pready_q & bad_addr;
			prdata_q <= (apb_acc & ~pready_q & ~pwrite & ~bad_addr) ? rd_word : 32'h0000_0000;
		end
	end

	// Writes to a pin-read address change nothing; status is read only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_q <= `EMI_PAGE_RESET;
			tim_q <= `EMI_TIM_RESET;
			mode_q <= `EMI_MODE_RESET;
			for (int i = 0; i < 4; i++) begin
				latch_q[i] <= `EMI_LATCH_RESET;
				pmode_q[i] <= `EMI_PMODE_RESET;
			end
		end else if (apb_acc && pready_q && pwrite && !bad_addr) begin
			case (paddr[5:4])
				`EMI_GRP_LATCH: latch_q[paddr[3:2]] <= pwdata[7:0];
				`EMI_GRP_PMODE: pmode_q[paddr[3:2]] <= pwdata[7:0]; // R8
				`EMI_GRP_PIN: ;
				default: begin
					case ({2'h0, paddr[5:0]})
						`EMI_OFS_PAGE: page_q <= pwdata[7:0];
						`EMI_OFS_TIM: tim_q <= pwdata[7:0]; // R12
						`EMI_OFS_MODE: mode_q <= pwdata[7:0]; // R11 R12
						default: ;
					endcase
				end
			endcase
		end
	end

	assign msel = emi_pkg::emi_mode_t'(mode_q[`EMI_MODE_SEL]);
	assign ea = mov_wide ? data_pointer : {page_q, mov_lo}; // R1

	always_comb begin
		case (msel)
			emi_pkg::EMI_INT_ONLY: off = 1'b0; // R11
			emi_pkg::EMI_EXT_ONLY: off = 1'b1;
			default: off = {1'b0, ea} >= ONCHIP_SIZE; // R17
		endcase
		// On-chip only mode wraps every address into the on-chip space.
		eff = off ? ea : ea & 16'((ONCHIP_SIZE - 17'h00001));
	end

	// Phase sequencer; zero-length setup and hold are skipped entirely.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		case (st_q)
			emi_pkg::EMI_IDLE: begin
				if (mov_req && off) begin
					if (tim_q[`EMI_TIM_SETUP] != 2'h0) begin
						st_d = emi_pkg::EMI_SETUP; // R18
						cnt_d = {3'h0, tim_q[`EMI_TIM_SETUP]} - 5'd1;
					end else if (!mode_q[`EMI_MODE_NONMUX]) begin
						st_d = emi_pkg::EMI_ALE_HI;
						cnt_d = {3'h0, mode_q[`EMI_MODE_ALEH]};
					end else begin
						st_d = emi_pkg::EMI_STROBE;
						cnt_d = {1'b0, tim_q[`EMI_TIM_PULSE]};
					end
				end
			end
			emi_pkg::EMI_SETUP: begin
				if (cnt_q != 5'd0) begin
					cnt_d = cnt_q - 5'd1;
				end else if (mux_q) begin
					st_d = emi_pkg::EMI_ALE_HI;
					cnt_d = {3'h0, mode_q[`EMI_MODE_ALEH]};
				end else begin
					st_d = emi_pkg::EMI_STROBE;
					cnt_d = {1'b0, tim_q[`EMI_TIM_PULSE]};
				end
			end
			emi_pkg::EMI_ALE_HI: begin
				if (cnt_q != 5'd0) begin
					cnt_d = cnt_q - 5'd1;
				end else begin
					st_d = emi_pkg::EMI_ALE_LO;
					cnt_d = {3'h0, mode_q[`EMI_MODE_ALEL]};
				end
			end
			emi_pkg::EMI_ALE_LO: begin
				if (cnt_q != 5'd0) begin
					cnt_d = cnt_q - 5'd1;
				end else begin
					st_d = emi_pkg::EMI_STROBE;
					cnt_d = {1'b0, tim_q[`EMI_TIM_PULSE]};
				end
			end
			emi_pkg::EMI_STROBE: begin
				if (cnt_q != 5'd0) begin
					cnt_d = cnt_q - 5'd1;
				end else if (tim_q[`EMI_TIM_HOLD] != 2'h0) begin
					st_d = emi_pkg::EMI_HOLD;
					cnt_d = {3'h0, tim_q[`EMI_TIM_HOLD]} - 5'd1;
				end else begin
					st_d = emi_pkg::EMI_OVH;
					cnt_d = `EMI_OVH_CYC - 5'd1; // R16
				end
			end
			emi_pkg::EMI_HOLD: begin
				if (cnt_q != 5'd0) begin
					cnt_d = cnt_q - 5'd1;
				end else begin
					st_d = emi_pkg::EMI_OVH;
					cnt_d = `EMI_OVH_CYC - 5'd1; // R16
				end
			end
			emi_pkg::EMI_OVH: begin
				if (cnt_q != 5'd0) begin
					cnt_d = cnt_q - 5'd1;
				end else begin
					st_d = emi_pkg::EMI_IDLE;
				end
			end
			default: st_d = emi_pkg::EMI_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= emi_pkg::EMI_IDLE;
			cnt_q <= 5'd0;
		end else begin
			st_q <= st_d; // R3
			cnt_q <= cnt_d;
		end
	end

	// Access parameters are frozen at the start so a move sees one consistent layout.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_q <= 1'b0;
			hi_q <= 1'b0;
			mux_q <= 1'b0;
			addr_q <= 16'h0000;
			wdata_q <= 8'h00;
		end else if (st_q == emi_pkg::EMI_IDLE && mov_req) begin
			wr_q <= mov_write;
			hi_q <= mov_wide || msel == emi_pkg::EMI_SPLIT_BANK;
			mux_q <= !mode_q[`EMI_MODE_NONMUX];
			addr_q <= eff; // R1
			wdata_q <= mov_wdata;
		end
	end

	// Read data is taken three cycles after the last strobe cycle: one for the pin
	// register and two for the synchroniser, so it matches the pin during the strobe.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_q <= 3'h0;
			rdata_q <= 8'h00;
			done_q <= 1'b0;
			onchip_q <= 1'b0;
		end else begin
			cap_q <= {cap_q[1:0], st_q == emi_pkg::EMI_STROBE && cnt_q == 5'd0 && !wr_q};
			if (cap_q[2]) begin
				rdata_q <= pin_s[31:24];
			end
			done_q <= (st_q == emi_pkg::EMI_IDLE && mov_req && !off) ||
				(st_q == emi_pkg::EMI_OVH && cnt_q == 5'd0); // R2 R5
			onchip_q <= st_q == emi_pkg::EMI_IDLE && mov_req && !off; // R2
		end
	end

	assign mov_done = done_q;
	assign mov_onchip = onchip_q;
	assign mov_rdata = rdata_q;
	assign mov_addr = addr_q;

	// Pin values and drivers; the port never turns on a driver the mode registers keep off.
	always_comb begin
		logic [7:0] inmask [4];
		logic addr_phase;
		addr_phase = st_q == emi_pkg::EMI_SETUP || st_q == emi_pkg::EMI_ALE_HI ||
			st_q == emi_pkg::EMI_ALE_LO;
		for (int i = 0; i < 4; i++) begin
			out_d[i] = latch_q[i]; // R5 R8
			inmask[i] = 8'h00;
		end
		if (st_q != emi_pkg::EMI_IDLE) begin // R4
			out_d[0][`EMI_PIN_RD] = !(st_q == emi_pkg::EMI_STROBE && !wr_q);
			out_d[0][`EMI_PIN_WR] = !(st_q == emi_pkg::EMI_STROBE && wr_q);
			if (mux_q) begin
				out_d[0][`EMI_PIN_ALE] = st_q == emi_pkg::EMI_ALE_HI; // R15
				out_d[3] = addr_phase ? addr_q[7:0] : wdata_q; // R9 R15
				inmask[3] = (!wr_q && !addr_phase) ? 8'hff : 8'h00; // R6
				if (hi_q) begin
					out_d[2] = addr_q[15:8];
				end
			end else begin
				out_d[3] = wdata_q; // R10
				inmask[3] = wr_q ? 8'h00 : 8'hff; // R6
				out_d[2] = addr_q[7:0];
				if (hi_q) begin
					out_d[1] = addr_q[15:8];
				end
			end
		end
		for (int i = 0; i < 4; i++) begin
			oe_d[i] = ~inmask[i] & (pmode_q[i] | ~out_d[i]); // R7 R8
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				out_q[i] <= `EMI_LATCH_RESET;
				oe_q[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				out_q[i] <= out_d[i];
				oe_q[i] <= oe_d[i];
			end
		end
	end

	assign p1_out = out_q[0];
	assign p1_oe = oe_q[0];
	assign p2_out = out_q[1];
	assign p2_oe = oe_q[1];
	assign p3_out = out_q[2];
	assign p3_oe = oe_q[2];
	assign p4_out = out_q[3];
	assign p4_oe = oe_q[3];
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// Cycle count of each off-chip access against the programmed figure.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_cyc_q <= 6'd0;
			exp_q <= 6'd0;
		end else if (st_q == emi_pkg::EMI_IDLE) begin
			busy_cyc_q <= 6'd0;
			exp_q <= {4'h0, tim_q[`EMI_TIM_SETUP]} + {2'h0, tim_q[`EMI_TIM_PULSE]} + 6'd1 +
				{4'h0, tim_q[`EMI_TIM_HOLD]} + 6'd4 + (mode_q[`EMI_MODE_NONMUX] ? 6'd0 :
				{4'h0, mode_q[`EMI_MODE_ALEH]} + {4'h0, mode_q[`EMI_MODE_ALEL]} + 6'd2);
		end else begin
			busy_cyc_q <= busy_cyc_q + 6'd1;
		end
	end

	a_total_time: assert property (@(posedge pclk) disable iff (!presetn) // R16
		mov_done && !mov_onchip |-> busy_cyc_q == exp_q)
		else $error("off-chip access length differs from programmed timing");
	a_onchip_fast: assert property (@(posedge pclk) disable iff (!presetn) // R2
		st_q == emi_pkg::EMI_IDLE && mov_req && !off |=> mov_done && mov_onchip)
		else $error("on-chip move not finished in one cycle");
	a_addr_form: assert property (@(posedge pclk) disable iff (!presetn) // R1
		st_q == emi_pkg::EMI_IDLE && mov_req && off |=>
		mov_addr == $past(mov_wide ? data_pointer : {page_q, mov_lo}))
		else $error("off-chip address not formed from pointer or page");
	a_split_route: assert property (@(posedge pclk) disable iff (!presetn) // R17
		st_q == emi_pkg::EMI_IDLE && mov_req && msel == emi_pkg::EMI_SPLIT_BANK &&
		{1'b0, ea} < ONCHIP_SIZE |=> mov_onchip)
		else $error("split mode low address not routed on-chip");
	a_pins_release: assert property (@(posedge pclk) disable iff (!presetn) // R5
		mov_done ##1 st_q == emi_pkg::EMI_IDLE |=> p3_out == $past(latch_q[2]) &&
		p1_out == $past(latch_q[0]))
		else $error("pins not handed back to latches after move");
	a_read_oe_off: assert property (@(posedge pclk) disable iff (!presetn) // R6
		st_q == emi_pkg::EMI_STROBE && !wr_q |=> p4_oe == 8'h00)
		else $error("data driver on during read strobe");
	a_ale_high: assert property (@(posedge pclk) disable iff (!presetn) // R15
		st_q == emi_pkg::EMI_ALE_HI |=> p1_out[`EMI_PIN_ALE] && p4_out == $past(addr_q[7:0]))
		else $error("latch strobe low or address missing in latch phase");
	a_strobe_pin: assert property (@(posedge pclk) disable iff (!presetn) // R18
		st_q == emi_pkg::EMI_STROBE |=> p1_out[`EMI_PIN_RD] == $past(wr_q) &&
		p1_out[`EMI_PIN_WR] == !$past(wr_q))
		else $error("read or write strobe wrong during strobe phase");
	a_idle_mode: assert property (@(posedge pclk) disable iff (!presetn) // R8
		st_q == emi_pkg::EMI_IDLE |=> p2_oe == $past(pmode_q[1] | ~latch_q[1]))
		else $error("latch-controlled pin mode not from mode register");
endmodule
`default_nettype wire

// [pkg/emi_defines.svh]
// Register offsets, field positions, reset values and timing counts of the memory port.
`ifndef EMI_DEFINES_SVH
`define EMI_DEFINES_SVH
`define EMI_OFS_PAGE 8'h00
`define EMI_OFS_TIM 8'h04
`define EMI_OFS_MODE 8'h08
`define EMI_OFS_STAT 8'h0c
`define EMI_GRP_LATCH 2'h1
`define EMI_GRP_PMODE 2'h2
`define EMI_GRP_PIN 2'h3
`define EMI_TIM_SETUP 7:6
`define EMI_TIM_PULSE 5:2
`define EMI_TIM_HOLD 1:0
`define EMI_MODE_NONMUX 6
`define EMI_MODE_SEL 5:4
`define EMI_MODE_ALEH 3:2
`define EMI_MODE_ALEL 1:0
`define EMI_PAGE_RESET 8'h00
`define EMI_TIM_RESET 8'hff
`define EMI_MODE_RESET 8'h0f
`define EMI_LATCH_RESET 8'hff
`define EMI_PMODE_RESET 8'h00
`define EMI_OVH_CYC 5'd4
`define EMI_PIN_ALE 3
`define EMI_PIN_RD 6
`define EMI_PIN_WR 7
`endif

// [pkg/emi_pkg.sv]
// Types shared by the memory port design.
`default_nettype none
package emi_pkg;
	typedef enum logic [2:0] {
		EMI_IDLE,
		EMI_SETUP,
		EMI_ALE_HI,
		EMI_ALE_LO,
		EMI_STROBE,
		EMI_HOLD,
		EMI_OVH
	} emi_state_t;
	typedef enum logic [1:0] {
		EMI_INT_ONLY,
		EMI_SPLIT_NOBANK,
		EMI_SPLIT_BANK,
		EMI_EXT_ONLY
	} emi_mode_t;
endpackage
`default_nettype wire

// [rtl/emi_sync.sv]
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module emi_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule
`default_nettype wire

// [tb/emi_sram_model.sv]
// Behavioural external byte memory hanging off the port pins.
`timescale 1ns/1ps
`default_nettype none
module emi_sram_model (
	input wire logic clk,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic ale,
	input wire logic muxed,
	input wire logic [7:0] ab_lo,
	input wire logic [7:0] ad,
	output logic [7:0] drv
);
	logic [7:0] mem [256];
	logic [7:0] lat;
	logic [7:0] last;
	logic [7:0] addr;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'h00;
		end
		last = 8'h00;
	end
	// The external latch is transparent while the strobe is high.
	always @* begin
		if (ale) begin
			lat = ad;
		end
	end
	assign addr = muxed ? lat : ab_lo;
	// Released data lines show the inverse of the last byte, so a stale capture is seen.
	assign drv = !rd_n ? mem[addr] : ~last;
	always @(posedge clk) begin
		if (!rd_n) begin
			last <= mem[addr];
		end
		if (!wr_n) begin
			mem[addr] <= ad;
		end
	end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the off-chip memory port.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [7:0] paddr = 8'h00, mov_lo = 8'h00, mov_wdata = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic mov_req = 1'b0, mov_write = 1'b0, mov_wide = 1'b0, mx_q = 1'b0;
	logic mov_done, mov_onchip;
	logic [15:0] data_pointer = 16'h0000, mov_addr;
	logic [7:0] mov_rdata, p1_out, p1_oe, p2_out, p2_oe, p3_out, p3_oe, p4_out, p4_oe, drv;
	logic [7:0] exp_mem [256];
	logic [7:0] hi_seen = 8'h00;
	int n_fail = 0, n_tests = 0, cyc = 0, seed = 32'hc30a;
	always #12.5 pclk = ~pclk;
	emi_off_chip_memory_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .mov_req(mov_req),
		.mov_write(mov_write), .mov_wide(mov_wide), .data_pointer(data_pointer),
		.mov_lo(mov_lo), .mov_wdata(mov_wdata), .mov_done(mov_done),
		.mov_onchip(mov_onchip), .mov_rdata(mov_rdata), .mov_addr(mov_addr),
		.p1_in(p1_out | ~p1_oe), .p1_out(p1_out), .p1_oe(p1_oe),
		.p2_in(p2_out | ~p2_oe), .p2_out(p2_out), .p2_oe(p2_oe),
		.p3_in(p3_out | ~p3_oe), .p3_out(p3_out), .p3_oe(p3_oe),
		.p4_in((p4_out & p4_oe) | (drv & ~p4_oe)), .p4_out(p4_out), .p4_oe(p4_oe));
	emi_sram_model u_mem (.clk(pclk), .rd_n(p1_out[6] | ~p1_oe[6]),
		.wr_n(p1_out[7] | ~p1_oe[7]), .ale(p1_out[3] & p1_oe[3]), .muxed(mx_q),
		.ab_lo(p3_out | ~p3_oe), .ad((p4_out & p4_oe) | (drv & ~p4_oe)), .drv(drv));
	task final_report;
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task chk_n(input int g, input int e);
		n_tests++;
		if (g != e) begin
			n_fail++;
			$display("[FAIL] t=%0t cycles got=%h exp=%h", $time, g, e);
		end
	endtask
	// The master holds the request until it samples pready high at a rising edge.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_fail++;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask
	task mov(input logic w, input logic wd, input logic [15:0] a, input logic [7:0] lo,
		input logic [7:0] d, input int en, input logic eon);
		int n;
		logic [7:0] ix;
		ix = wd ? a[7:0] : lo;
		mov_req <= 1'b1;
		mov_write <= w;
		mov_wide <= wd;
		data_pointer <= a;
		mov_lo <= lo;
		mov_wdata <= d;
		@(posedge pclk);
		mov_req <= 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (mov_done !== 1'b1 && n < 100);
		chk_n(n, en);
		chk({31'h0, mov_onchip}, {31'h0, eon});
		if (!eon && w) begin
			exp_mem[ix] = d;
			chk(u_mem.mem[ix], d);
		end else if (!eon) begin
			chk(mov_rdata, exp_mem[ix]);
		end
		@(negedge pclk);
		chk({p1_out, p2_out, p3_out, p4_oe}, 32'hf7ffffff);
		chk({p1_oe, p2_oe}, 16'hffff);
		@(posedge pclk);
	endtask
	always @(negedge pclk) begin
		if (presetn && !p1_out[6]) begin
			chk(p4_oe, 8'h00);
		end
		if (presetn && (!p1_out[6] || !p1_out[7])) begin
			hi_seen <= p2_out;
		end
		if (mx_q && p1_out[3]) begin
			chk({p1_out[7:6], p4_oe}, {2'b11, 8'hff});
		end
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			final_report;
		end
	end
	initial begin
		logic [7:0] t, m, d;
		logic [15:0] a;
		int en;
		for (int i = 0; i < 256; i++) begin
			exp_mem[i] = 8'h00;
		end
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 12; i++) begin
			rd_chk(8'(i * 4), (i == 1 || (i > 3 && i < 8)) ? 32'hff : {28'h0, i == 2 ? 4'hf : 4'h0}, 1'b0);
		end
		rd_chk(8'h40, 32'h0, 1'b1);
		rd_chk(8'h05, 32'h0, 1'b1);
		wr(8'h0c, 32'hff);
		rd_chk(8'h0c, 32'h0, 1'b0);
		wr(8'h18, 32'ha5);
		@(negedge pclk);
		chk({p3_out, p3_oe}, 16'ha55a);
		@(posedge pclk);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			wr(8'(8'h20 + i * 4), 32'hff);
		end
		wr(8'h18, 32'hff);
		wr(8'h10, 32'hf7);
		for (int i = 0; i < 8; i++) begin
			t = (i < 2) ? 8'h00 : 8'($random(seed));
			m = {1'b0, ~i[0], 2'b11, 4'($random(seed))};
			a = 16'($random(seed));
			d = 8'($random(seed));
			en = t[7:6] + t[5:2] + 1 + t[1:0] + 4 + 1;
			if (i[0]) begin
				en = en + m[3:2] + m[1:0] + 2;
			end
			mx_q <= i[0];
			wr(8'h08, {24'h0, m});
			wr(8'h04, {24'h0, t});
			mov(1'b1, 1'b1, a, 8'h00, d, en, 1'b0);
			chk(mov_addr, a);
			mov(1'b0, 1'b1, a, 8'h00, 8'h00, en, 1'b0);
		end
		mx_q <= 1'b0;
		$display("test off-chip timing done");
		wr(8'h08, 32'h50);
		wr(8'h04, 32'h00);
		mov(1'b0, 1'b1, 16'h07ff, 8'h00, 8'h00, 1, 1'b1);
		mov(1'b0, 1'b1, 16'h0800, 8'h00, 8'h00, 6, 1'b0);
		wr(8'h00, 32'h12);
		mov(1'b1, 1'b0, 16'h0000, 8'h34, 8'h5c, 6, 1'b0);
		chk(mov_addr, 16'h1234);
		wr(8'h08, 32'h60);
		mov(1'b0, 1'b0, 16'h0000, 8'h34, 8'h00, 6, 1'b0);
		chk(hi_seen, 8'h12);
		rd_chk(8'h0c, 32'h5c, 1'b0);
		wr(8'h08, 32'h40);
		mov(1'b1, 1'b1, 16'habcd, 8'h00, 8'h77, 1, 1'b1);
		chk(mov_addr, 16'h03cd);
		rd_chk(8'h3c, 32'hff, 1'b0);
		$display("test memory modes done");
		final_report;
	end
endmodule
`default_nettype wire
